// ### rtl/eda_event_action.v
// external debug event action logic with configuration register and interrupt status
// Summary of operation
// [RULE1] on event, count field starts, stops or toggles task-mode performance counters
// [RULE2] on event, suspend-out takes the configured suspend value
// [RULE3] break-out disable set means the break-out pin never pulses
// [RULE4] order bit: 0 pulses after the action, 1 pulses before it
// [RULE5] action field picks the action; code zero ignores the event completely
// [RULE6] codes one to three: pulse only, halt plus pulse, trap plus pulse
// [RULE7] codes four to seven raise breakpoint interrupts 0..3 when implemented
// [RULE8] with break-out disabled the same actions occur with no pulse
// [RULE9] configuration resets to zero; bits 31 to 8 read as zero
// [RULE10] the event reports source code zero to the debug status register
// [RULE11] the break-out pulse is one cycle long, once per event
`timescale 1ns/1ps
`include "eda_map.vh"

module eda_event_action (
    // clock and reset
    input  wire                   core_clk,
    input  wire                   rst_b,
    // register port
    input  wire [`EDA_ADDR_W-1:0] regAddr,
    input  wire [31:0]            regWrData,
    input  wire                   regWrStb,
    input  wire                   regRdStb,
    output reg  [31:0]            regRdData_ff,
    // external debug event pin
    input  wire                   extEventPin,
    // actions toward the core
    output reg                    haltReq_ff,
    output reg                    trapReq_ff,
    output reg  [3:0]             bkptIrq_ff,
    // break-out pin
    output reg                    breakoutPin_ff,
    // suspend-out and performance counters
    output reg                    suspendOut_ff,
    output reg                    prevSuspend_ff,
    output reg                    perfCountRun_ff,
    // debug status register update
    output reg                    statusUpdate_ff,
    output reg  [4:0]             eventSourceCode_ff,
    // interrupt
    output wire                   irqOut
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function addrHit;
        input [`EDA_ADDR_W-1:0] a;
        input [`EDA_ADDR_W-1:0] off;
        begin
            addrHit = (a == off);
        end
    endfunction

    // one-hot breakpoint interrupt for a code, zero if not implemented
    function [3:0] bkptDecode;
        input [2:0] code;
        reg   [3:0] sel;
        begin
            sel = 4'h0;
            case (code)
                3'h4:    sel = 4'h1;
                3'h5:    sel = 4'h2;
                3'h6:    sel = 4'h4;
                3'h7:    sel = 4'h8;
                default: sel = 4'h0;
            endcase
            bkptDecode = sel & `EDA_BKPT_IMPL;
        end
    endfunction

    // kinds of action of a code: [2] breakpoint interrupt, [1] trap, [0] halt
    function [2:0] actKind;
        input [2:0] code;
        reg   [2:0] kinds;
        begin
            kinds    = 3'h0;
            kinds[0] = (code == `EDA_ACT_HALT);
            kinds[1] = (code == `EDA_ACT_TRAP);
            kinds[2] = (bkptDecode(code) != 4'h0);
            actKind  = kinds;
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [`EDA_CFG_W-1:0] config_ff;
    reg [`EDA_IRQ_W-1:0] irqStatus_ff;
    reg [`EDA_IRQ_W-1:0] irqMask_ff;

    wire wrConfig = regWrStb && addrHit(regAddr, `EDA_OFF_CONFIG);
    wire wrStatus = regWrStb && addrHit(regAddr, `EDA_OFF_IRQ_STATUS);
    wire wrMask   = regWrStb && addrHit(regAddr, `EDA_OFF_IRQ_MASK);

    wire [1:0] cfgCnt  = config_ff[`EDA_CNT_HI:`EDA_CNT_LO];
    wire       cfgSusp = config_ff[`EDA_SUSPEND_OUT_VALUE_BIT];
    wire       cfgBod  = config_ff[`EDA_BOD_BIT];
    wire       cfgBbm  = config_ff[`EDA_BBM_BIT];
    wire [2:0] cfgEvta = config_ff[`EDA_EVENT_ACTION_CODE_HI:`EDA_EVENT_ACTION_CODE_LO];

    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    reg [`EDA_CFG_W-1:0] nxt_config;

    // only the low byte is kept; reserved bits of a write are dropped
    always @* begin
        nxt_config = config_ff;
        if (wrConfig) begin
            nxt_config = regWrData[`EDA_CFG_W-1:0]; // [RULE9]
        end
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            config_ff <= `EDA_CFG_RESET; // [RULE9]
        end else begin
            config_ff <= nxt_config;
        end
    end

    // ----------------------------------------
    // event pin synchroniser
    // ----------------------------------------
    reg sync1_ff;
    reg sync2_ff;
    reg sync3_ff;
    reg evtLevel_ff;

    // stages two and three agree: the pin has settled at that level
    wire syncAgree = (sync2_ff == sync3_ff);

    always @(posedge core_clk) begin
        if (!rst_b) begin
            sync1_ff    <= 1'b0;
            sync2_ff    <= 1'b0;
            sync3_ff    <= 1'b0;
            evtLevel_ff <= 1'b0;
        end else begin
            sync1_ff <= extEventPin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (syncAgree) begin
                evtLevel_ff <= sync3_ff;
            end
        end
    end

    wire evtRise = syncAgree && sync3_ff && !evtLevel_ff;

    // ----------------------------------------
    // event acceptance
    // ----------------------------------------
    wire seqBusy;
    wire eventEnabled = (cfgEvta != `EDA_ACT_DISABLED); // [RULE5]
    wire eventTaken   = evtRise && eventEnabled && !seqBusy;
    wire eventDropped = evtRise && eventEnabled && seqBusy;

    wire wantPulse  = !cfgBod; // [RULE3]
    wire [2:0] cfgKind    = actKind(cfgEvta);
    wire       wantAction = |cfgKind; // [RULE6]

    // action code is held for the duration of the sequence
    reg [2:0] actCode_ff;

    reg [2:0] nxt_actCode;

    always @* begin
        nxt_actCode = actCode_ff;
        if (eventTaken) begin
            nxt_actCode = cfgEvta;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            actCode_ff <= `EDA_ACT_DISABLED;
        end else begin
            actCode_ff <= nxt_actCode;
        end
    end

    // ----------------------------------------
    // ordering of action and break-out pulse
    // ----------------------------------------
    wire fireAction;
    wire firePulse;

    eda_breakout_seq u_seq (
        .core_clk        (core_clk),
        .rst_b           (rst_b),
        .start           (eventTaken),
        .wantAction      (wantAction),
        .wantPulse       (wantPulse),
        .breakBeforeMake (cfgBbm),
        .fireAction_ff   (fireAction),
        .firePulse_ff    (firePulse),
        .busy            (seqBusy)
    );

    // ----------------------------------------
    // decoded action of the running sequence
    // ----------------------------------------
    wire [2:0] runKind  = actKind(actCode_ff);
    wire       fireHalt = fireAction && runKind[0];
    wire       fireTrap = fireAction && runKind[1];
    wire       fireBkpt = fireAction && runKind[2];
    wire [3:0] fireIrq  = fireAction ? bkptDecode(actCode_ff) : 4'h0;

    // ----------------------------------------
    // action outputs
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!rst_b) begin
            haltReq_ff     <= 1'b0;
            trapReq_ff     <= 1'b0;
            bkptIrq_ff     <= 4'h0;
            breakoutPin_ff <= 1'b0;
        end else begin
            haltReq_ff     <= fireHalt; // [RULE6]
            trapReq_ff     <= fireTrap; // [RULE6]
            bkptIrq_ff     <= fireIrq; // [RULE7]
            // a disabled break-out never reaches the sequencer as a pulse
            breakoutPin_ff <= firePulse; // [RULE8]
        end
    end

    // ----------------------------------------
    // suspend-out, counters and status report
    // ----------------------------------------
    reg nxt_perfCountRun;

    always @* begin
        nxt_perfCountRun = perfCountRun_ff;
        if (eventTaken) begin
            case (cfgCnt)
                `EDA_CNT_START:  nxt_perfCountRun = 1'b1; // [RULE1]
                `EDA_CNT_STOP:   nxt_perfCountRun = 1'b0; // [RULE1]
                `EDA_CNT_TOGGLE: nxt_perfCountRun = ~perfCountRun_ff; // [RULE1]
                default:         nxt_perfCountRun = perfCountRun_ff;
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            perfCountRun_ff    <= 1'b0;
            suspendOut_ff      <= 1'b0;
            prevSuspend_ff     <= 1'b0;
            statusUpdate_ff    <= 1'b0;
            eventSourceCode_ff <= 5'h00;
        end else begin
            perfCountRun_ff <= nxt_perfCountRun;
            statusUpdate_ff <= eventTaken;
            if (eventTaken) begin
                prevSuspend_ff     <= suspendOut_ff;
                suspendOut_ff      <= cfgSusp; // [RULE2]
                eventSourceCode_ff <= `EDA_EVENT_SOURCE_CODE_EXT; // [RULE10]
            end
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    wire [`EDA_IRQ_W-1:0] irqEvents;

    assign irqEvents[`EDA_IRQ_EVENT] = eventTaken;
    assign irqEvents[`EDA_IRQ_HALT]  = fireHalt;
    assign irqEvents[`EDA_IRQ_TRAP]  = fireTrap;
    assign irqEvents[`EDA_IRQ_BKPT]  = fireBkpt;
    assign irqEvents[`EDA_IRQ_DROP]  = eventDropped;

    reg [`EDA_IRQ_W-1:0] nxt_irqStatus;
    reg [`EDA_IRQ_W-1:0] nxt_irqMask;

    // a new event wins over a write-one clear in the same cycle
    always @* begin
        nxt_irqStatus = irqStatus_ff | irqEvents;
        if (wrStatus) begin
            nxt_irqStatus = (irqStatus_ff & ~regWrData[`EDA_IRQ_W-1:0]) | irqEvents;
        end
        nxt_irqMask = irqMask_ff;
        if (wrMask) begin
            nxt_irqMask = regWrData[`EDA_IRQ_W-1:0];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            irqStatus_ff <= {`EDA_IRQ_W{1'b0}};
            irqMask_ff   <= {`EDA_IRQ_W{1'b0}};
        end else begin
            irqStatus_ff <= nxt_irqStatus;
            irqMask_ff   <= nxt_irqMask;
        end
    end

    assign irqOut = |(irqStatus_ff & irqMask_ff);

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // readable image of each register, reserved bits zero
    wire [31:0] cfgWord   = {24'h000000, config_ff}; // [RULE9]
    wire [31:0] statWord  = {27'h0000000, irqStatus_ff};
    wire [31:0] maskWord  = {27'h0000000, irqMask_ff};
    wire [31:0] stateWord = {19'h00000, eventSourceCode_ff, 4'h0,
                             seqBusy, prevSuspend_ff, suspendOut_ff, perfCountRun_ff};
    reg  [31:0] nxt_regRdData;

    always @* begin
        nxt_regRdData = 32'h0000_0000;
        if (regRdStb) begin
            case (regAddr)
                `EDA_OFF_CONFIG: begin
                    nxt_regRdData = cfgWord; // [RULE9]
                end
                `EDA_OFF_IRQ_STATUS: begin
                    nxt_regRdData = statWord;
                end
                `EDA_OFF_IRQ_MASK: begin
                    nxt_regRdData = maskWord;
                end
                `EDA_OFF_STATE: begin
                    nxt_regRdData = stateWord;
                end
                default: begin
                    nxt_regRdData = 32'h0000_0000;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            regRdData_ff <= 32'h0000_0000;
        end else begin
            regRdData_ff <= nxt_regRdData;
        end
    end

endmodule // eda_event_action

// ### rtl/eda_map.vh
// register offsets, field positions, reset values and action codes of the external event block
`ifndef EDA_MAP_VH
`define EDA_MAP_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define EDA_ADDR_W          16
`define EDA_OFF_CONFIG      16'hfd08
`define EDA_OFF_IRQ_STATUS  16'hfd40
`define EDA_OFF_IRQ_MASK    16'hfd44
`define EDA_OFF_STATE       16'hfd48

// ----------------------------------------
// external_event_config fields
// ----------------------------------------
`define EDA_CFG_RESET       8'h00
`define EDA_CFG_W           8
`define EDA_CNT_HI          7
`define EDA_CNT_LO          6
`define EDA_SUSPEND_OUT_VALUE_BIT        5
`define EDA_BOD_BIT         4
`define EDA_BBM_BIT         3
`define EDA_EVENT_ACTION_CODE_HI         2
`define EDA_EVENT_ACTION_CODE_LO         0

// ----------------------------------------
// event_action_code values
// ----------------------------------------
`define EDA_ACT_DISABLED    3'h0
`define EDA_ACT_PULSE       3'h1
`define EDA_ACT_HALT        3'h2
`define EDA_ACT_TRAP        3'h3
`define EDA_ACT_BKPT0       3'h4

// ----------------------------------------
// perf_counter_action values
// ----------------------------------------
`define EDA_CNT_KEEP        2'h0
`define EDA_CNT_START       2'h1
`define EDA_CNT_STOP        2'h2
`define EDA_CNT_TOGGLE      2'h3

// ----------------------------------------
// event source code of the external event
// ----------------------------------------
`define EDA_EVENT_SOURCE_CODE_EXT      5'h00

// ----------------------------------------
// implemented breakpoint interrupts, one bit each
// ----------------------------------------
`define EDA_BKPT_IMPL       4'h3

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define EDA_IRQ_W           5
`define EDA_IRQ_EVENT       0
`define EDA_IRQ_HALT        1
`define EDA_IRQ_TRAP        2
`define EDA_IRQ_BKPT        3
`define EDA_IRQ_DROP        4

`endif

// ### rtl/eda_breakout_seq.v
// two-phase sequencer ordering the break-out pulse against the debug action
`timescale 1ns/1ps

module eda_breakout_seq (
    // clock and reset
    input  wire core_clk,
    input  wire rst_b,
    // request
    input  wire start,
    input  wire wantAction,
    input  wire wantPulse,
    input  wire breakBeforeMake,
    // phase outputs
    output reg  fireAction_ff,
    output reg  firePulse_ff,
    output wire busy
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE   = 1'b0;
    localparam ST_SECOND = 1'b1;

    reg state_ff;
    reg pendAction_ff;
    reg pendPulse_ff;

    assign busy = (state_ff != ST_IDLE);

    always @(posedge core_clk) begin
        if (!rst_b) begin
            state_ff      <= ST_IDLE;
            fireAction_ff <= 1'b0;
            firePulse_ff  <= 1'b0;
            pendAction_ff <= 1'b0;
            pendPulse_ff  <= 1'b0;
        end else begin
            fireAction_ff <= 1'b0;
            firePulse_ff  <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (start && wantAction && wantPulse) begin
                        // one of the two now, the other one cycle later
                        firePulse_ff  <= breakBeforeMake; // [RULE4]
                        fireAction_ff <= ~breakBeforeMake; // [RULE4]
                        pendPulse_ff  <= ~breakBeforeMake;
                        pendAction_ff <= breakBeforeMake;
                        state_ff      <= ST_SECOND;
                    end else if (start) begin
                        fireAction_ff <= wantAction;
                        firePulse_ff  <= wantPulse; // [RULE11]
                    end
                end
                ST_SECOND: begin
                    fireAction_ff <= pendAction_ff;
                    firePulse_ff  <= pendPulse_ff; // [RULE11]
                    pendAction_ff <= 1'b0;
                    pendPulse_ff  <= 1'b0;
                    state_ff      <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // eda_breakout_seq

// ### verif/eda_event_action_props.sv
// assertion checker for the external debug event action block
`timescale 1ns/1ps
`include "eda_map.vh"

module eda_event_action_props (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // register port
    input wire logic        regRdStb,
    input wire logic [31:0] regRdData_ff,
    // event outputs
    input wire logic        haltReq_ff,
    input wire logic        trapReq_ff,
    input wire logic [3:0]  bkptIrq_ff,
    input wire logic        breakoutPin_ff,
    input wire logic        suspendOut_ff,
    input wire logic        prevSuspend_ff,
    input wire logic        perfCountRun_ff,
    input wire logic        statusUpdate_ff,
    input wire logic [4:0]  eventSourceCode_ff
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    logic anyAct;
    assign anyAct = haltReq_ff | trapReq_ff | (|bkptIrq_ff);

    // pulses belong to the two cycles after an accepted event
    sequence s_recent_evt;
        $past(statusUpdate_ff) || $past(statusUpdate_ff, 2);
    endsequence

    a_pulse_window: assert property (breakoutPin_ff |-> s_recent_evt)
        else $error("break-out pulse outside an event");
    a_action_window: assert property (anyAct |-> s_recent_evt)
        else $error("action pulse outside an event");
    a_pulse_single: assert property (breakoutPin_ff |=> !breakoutPin_ff)
        else $error("break-out pulse longer than one cycle");
    a_pulse_apart: assert property (!(breakoutPin_ff && anyAct))
        else $error("break-out and action in the same cycle");
    a_bkpt_impl: assert property (bkptIrq_ff[3:2] == 2'b00 && $onehot0(bkptIrq_ff))
        else $error("unimplemented or multiple breakpoint interrupts");
    a_source_zero: assert property (statusUpdate_ff |-> eventSourceCode_ff == `EDA_EVENT_SOURCE_CODE_EXT)
        else $error("wrong event source code");
    a_prev_suspend_out_value: assert property (statusUpdate_ff |-> prevSuspend_ff == $past(suspendOut_ff))
        else $error("previous suspend value not kept");
    a_level_hold: assert property (!statusUpdate_ff |-> $stable(perfCountRun_ff) && $stable(suspendOut_ff))
        else $error("level changed without an event");
    a_read_quiet: assert property (!regRdStb |=> regRdData_ff == 32'h0)
        else $error("read data outside a read");
endmodule // eda_event_action_props

bind eda_event_action eda_event_action_props chk (
    .core_clk(core_clk), .rst_b(rst_b), .regRdStb(regRdStb), .regRdData_ff(regRdData_ff),
    .haltReq_ff(haltReq_ff), .trapReq_ff(trapReq_ff), .bkptIrq_ff(bkptIrq_ff),
    .breakoutPin_ff(breakoutPin_ff), .suspendOut_ff(suspendOut_ff), .prevSuspend_ff(prevSuspend_ff),
    .perfCountRun_ff(perfCountRun_ff), .statusUpdate_ff(statusUpdate_ff),
    .eventSourceCode_ff(eventSourceCode_ff)
);

// ### verif/eda_core_model.sv
// far-side model: drives the event pin and records when core-side pulses arrive
`timescale 1ns/1ps

module eda_core_model (
    // clock and trigger
    input  wire logic       core_clk,
    input  wire logic       trig,
    // pulses from the block
    input  wire logic       haltReq,
    input  wire logic       trapReq,
    input  wire logic [3:0] bkptIrq,
    input  wire logic       breakoutPin,
    input  wire logic       statusUpdate,
    // event pin and observations
    output logic            extEventPin,
    output logic [7:0]      actAt,
    output logic [7:0]      brkAt,
    output logic [7:0]      updAt,
    output logic [5:0]      actKind,
    output logic [3:0]      nBrk
);
    logic [7:0] cnt    = 8'h00;
    logic       pinLvl = 1'b0;

    assign extEventPin = pinLvl;

    // cycle stamps relative to the pin rise; pin falls again so the next edge is clean
    always @(posedge core_clk) begin
        cnt <= cnt + 8'h01;
        if (cnt == 8'h06)
            pinLvl <= 1'b0;
        if (haltReq | trapReq | (|bkptIrq)) begin
            actAt <= cnt;
            actKind <= {haltReq, trapReq, bkptIrq};
        end
        if (breakoutPin) begin
            brkAt <= cnt;
            nBrk <= nBrk + 4'h1;
        end
        if (statusUpdate)
            updAt <= cnt;
        if (trig) begin
            cnt <= 8'h00;
            pinLvl <= 1'b1;
            actAt <= 8'hff;
            brkAt <= 8'hff;
            updAt <= 8'hff;
            actKind <= 6'h00;
            nBrk <= 4'h0;
        end
    end
endmodule // eda_core_model

// ### verif/tb_top.sv
// self-checking testbench for the external debug event action block
`timescale 1ns/1ps
`include "eda_map.vh"

module tb_top;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [31:0] regWrData = 32'h0;
    logic        regWrStb = 1'b0;
    logic        regRdStb = 1'b0;
    logic        trig = 1'b0;
    wire  [31:0] regRdData_ff;
    wire         extEventPin, haltReq_ff, trapReq_ff, breakoutPin_ff, suspendOut_ff;
    wire         prevSuspend_ff, perfCountRun_ff, statusUpdate_ff, irqOut;
    wire  [3:0]  bkptIrq_ff, nBrk;
    wire  [4:0]  eventSourceCode_ff;
    wire  [7:0]  actAt, brkAt, updAt;
    wire  [5:0]  actKind;
    int          n_errors = 0;
    int          n_compared = 0;
    logic        suspend_out_value = 1'b0;
    logic        run = 1'b0;

    always #5 core_clk = ~core_clk;

    eda_event_action uut (
        .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_ff(regRdData_ff), .extEventPin(extEventPin),
        .haltReq_ff(haltReq_ff), .trapReq_ff(trapReq_ff), .bkptIrq_ff(bkptIrq_ff),
        .breakoutPin_ff(breakoutPin_ff), .suspendOut_ff(suspendOut_ff), .prevSuspend_ff(prevSuspend_ff),
        .perfCountRun_ff(perfCountRun_ff), .statusUpdate_ff(statusUpdate_ff),
        .eventSourceCode_ff(eventSourceCode_ff), .irqOut(irqOut));

    eda_core_model partner (
        .core_clk(core_clk), .trig(trig), .haltReq(haltReq_ff), .trapReq(trapReq_ff), .bkptIrq(bkptIrq_ff),
        .breakoutPin(breakoutPin_ff), .statusUpdate(statusUpdate_ff), .extEventPin(extEventPin),
        .actAt(actAt), .brkAt(brkAt), .updAt(updAt), .actKind(actKind), .nBrk(nBrk));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1;
        check(regRdData_ff, exp);
    endtask

    // one pin event under configuration c, then timing and levels
    task automatic fire(input logic [7:0] c);
        logic [5:0] kind;
        logic       pulse;
        logic [7:0] brkExp;
        logic [7:0] actExp;
        kind = (c[2:0] == `EDA_ACT_HALT) ? 6'h20 : (c[2:0] == `EDA_ACT_TRAP) ? 6'h10 :
               (c[2:0] == `EDA_ACT_BKPT0) ? 6'h01 : (c[2:0] == 3'h5) ? 6'h02 : 6'h00;
        pulse = !c[4] && (c[2:0] != `EDA_ACT_DISABLED);
        brkExp = updAt;
        wr(`EDA_OFF_CONFIG, {24'h0, c});
        @(posedge core_clk);
        trig <= 1'b1;
        @(posedge core_clk);
        trig <= 1'b0;
        repeat (14) @(posedge core_clk);
        #1;
        brkExp = updAt + ((kind != 6'h00 && !c[3]) ? 8'h02 : 8'h01);
        actExp = updAt + ((pulse && c[3]) ? 8'h02 : 8'h01);
        check(actKind, kind);
        check(nBrk, pulse);
        if (pulse)
            check(brkAt, brkExp);
        if (kind != 6'h00)
            check(actAt, actExp);
        if (c[2:0] == `EDA_ACT_DISABLED) begin
            check(updAt, 8'hff);
        end else begin
            check({prevSuspend_ff, suspendOut_ff}, {suspend_out_value, c[5]});
            suspend_out_value = c[5];
            if (c[7:6] == `EDA_CNT_START)
                run = 1'b1;
            if (c[7:6] == `EDA_CNT_STOP)
                run = 1'b0;
            if (c[7:6] == `EDA_CNT_TOGGLE)
                run = ~run;
            check(perfCountRun_ff, run);
            check(eventSourceCode_ff, 5'h00);
        end
    endtask

    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        complete_run;
    end

    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(`EDA_OFF_CONFIG, 32'h0);
        wr(`EDA_OFF_CONFIG, 32'hffff_ffff);
        rd(`EDA_OFF_CONFIG, 32'h0000_00ff);
        rd(16'hfd0c, 32'h0);
        for (int i = 0; i < 32; i++)
            fire({i[1:0] ^ i[4:3], i[2] ^ i[0], i[4], i[3], i[2:0]});
        // last two events set suspend to one, then to zero; sequencer idle, source zero
        rd(`EDA_OFF_STATE, {28'h0, 2'b01, suspend_out_value, run});
        rd(`EDA_OFF_IRQ_STATUS, 32'h0000_000f);
        check(irqOut, 1'b0);
        wr(`EDA_OFF_IRQ_MASK, 32'h4);
        #1;
        check(irqOut, 1'b1);
        wr(`EDA_OFF_IRQ_STATUS, 32'h4);
        #1;
        check(irqOut, 1'b0);
        rd(`EDA_OFF_IRQ_STATUS, 32'h0000_000b);
        rd(`EDA_OFF_IRQ_MASK, 32'h4);
        wr(`EDA_OFF_IRQ_STATUS, 32'h1f);
        rd(`EDA_OFF_IRQ_STATUS, 32'h0);
        complete_run;
    end
endmodule // tb_top
